// ### common/rsb_pkg.sv
// Package with register map, field layout, reset values and timing for the receive slip buffer.
package rsb_pkg;

  // APB address width and register indices; byte address is four times the index.
  localparam int unsigned APB_AW        = 12;
  localparam logic [9:0]  IDX_SB_CTRL   = 10'h116;
  localparam logic [9:0]  IDX_FIFO_LAT  = 10'h117;
  localparam logic [9:0]  IDX_STATUS    = 10'h118;
  localparam logic [11:0] ADDR_SB_CTRL  = {IDX_SB_CTRL, 2'b00};
  localparam logic [11:0] ADDR_FIFO_LAT = {IDX_FIFO_LAT, 2'b00};
  localparam logic [11:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};

  // Slip buffer control fields.
  localparam int unsigned SBC_MODE_LSB  = 0;
  localparam int unsigned SBC_MODE_MSB  = 1;
  localparam int unsigned SBC_SDIR_BIT  = 2;
  localparam logic [1:0]  SBC_MODE_RST  = 2'h3;
  localparam logic        SBC_SDIR_RST  = 1'b1;

  // Buffer mode encodings; 00 and 11 both bypass.
  localparam logic [1:0]  MODE_SLIP     = 2'h1;
  localparam logic [1:0]  MODE_FIFO     = 2'h2;

  // FIFO latency field.
  localparam int unsigned LAT_MSB       = 4;
  localparam logic [4:0]  LAT_RST       = 5'h04;

  // Status fields, write one to clear.
  localparam int unsigned ST_DROP_BIT   = 0;
  localparam int unsigned ST_REPEAT_BIT = 1;

  // Bypass serial clock generated from pclk; the 488 ns target rounds down to 9 pclk periods per half period, so 450 ns (about 2.22 MHz).
  localparam int unsigned PCLK_PERIOD_NS    = 25;
  localparam int unsigned BYP_CLK_PERIOD_NS = 488;
  localparam int unsigned BYP_HALF_CYC      = BYP_CLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

  // Read side state of the link domain.
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RUN,
    RD_REPEAT
  } rsb_rd_state_t;

endpackage

// ### core/rsb_top.sv
// Receive slip buffer with mode control, FIFO latency and APB register access.
`timescale 1ns/100ps
// How it works
// - Mode field value 01 selects slip-buffer operation.
// - Mode 00 or 11 bypasses the buffer; clock and frame sync pins drive out.
// - Mode 10 runs the buffer as a FIFO with latency from register 0x117.
// - In slip and FIFO modes the serial clock pin is an input from backplane.
// - In buffered modes sync direction bit 2 picks sync pin: 0 out, 1 in.
// - Mode field resets to 11, so the buffer starts bypassed.
// - Five-bit latency field resets to 4 and holds FIFO data until that many bits are stored.
// - Latency field has no effect outside FIFO mode.
module rsb_top #(
  parameter int unsigned DEPTH      = 512,
  parameter int unsigned FRAME_BITS = 256
) (
  // APB clock and reset.
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave.
  input  wire logic [rsb_pkg::APB_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Receive line stream from the framer, on pclk.
  input  wire logic                       line_bit,
  input  wire logic                       line_bit_valid,
  input  wire logic                       line_frame_start,
  // Backplane serial clock pin.
  input  wire logic                       rx_serial_clock_pin_i,
  output logic                            rx_serial_clock_pin_o,
  output logic                            rx_serial_clock_pin_oe,
  // Backplane frame sync pin.
  input  wire logic                       rx_frame_sync_pin_i,
  output logic                            rx_frame_sync_pin_o,
  output logic                            rx_frame_sync_pin_oe,
  // Backplane receive data.
  output logic                            rx_data_o
);
  import rsb_pkg::*;

  localparam int unsigned AW    = $clog2(DEPTH);
  localparam int unsigned BCW   = $clog2(BYP_HALF_CYC + 1);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
  localparam logic [AW:0] FRAME_W = (AW+1)'(FRAME_BITS);
  localparam logic [BCW-1:0] BYP_LAST = BCW'(BYP_HALF_CYC - 1);

  if (DEPTH < 64 || DEPTH != (1 << AW) || FRAME_BITS < 2 || DEPTH < 2 * FRAME_BITS) begin : g_bad_param
    $error("rsb_top: DEPTH must be a power of two, at least 64 and at least twice FRAME_BITS");
  end

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Register file.
  logic [1:0]  mode_ff;
  logic        sdir_ff;
  logic [4:0]  lat_ff;
  logic [1:0]  sticky_ff;
  logic [31:0] prdata_ff;
  logic        cfg_written_ff;
  logic        setup;
  logic        wr_ctrl;
  logic        wr_lat;
  logic        wr_stat;
  logic        mapped;
  logic        buf_mode;
  logic        slip_mode;
  logic        fifo_mode;
  logic [1:0]  sticky_set;

  always_comb begin
    setup     = psel & ~penable;
    mapped    = (paddr == ADDR_SB_CTRL) | (paddr == ADDR_FIFO_LAT) | (paddr == ADDR_STATUS);
    wr_ctrl   = psel & penable & pwrite & (paddr == ADDR_SB_CTRL);
    wr_lat    = psel & penable & pwrite & (paddr == ADDR_FIFO_LAT);
    wr_stat   = psel & penable & pwrite & (paddr == ADDR_STATUS);
    slip_mode = (mode_ff == MODE_SLIP);
    fifo_mode = (mode_ff == MODE_FIFO);
    buf_mode  = slip_mode | fifo_mode;
    pready    = 1'b1;
    pslverr   = psel & penable & ~mapped;
    prdata    = prdata_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= SBC_MODE_RST;
      sdir_ff <= SBC_SDIR_RST;
    end else if (wr_ctrl) begin
      mode_ff <= pwdata[SBC_MODE_MSB:SBC_MODE_LSB];
      sdir_ff <= pwdata[SBC_SDIR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_ff <= LAT_RST;
    end else if (wr_lat) begin
      lat_ff <= pwdata[LAT_MSB:0];
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_ff <= 2'h0;
    end else begin
      sticky_ff <= (sticky_ff & ~(wr_stat ? pwdata[1:0] : 2'h0)) | sticky_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (setup) begin
      unique case (paddr)
        ADDR_SB_CTRL:  prdata_ff <= {29'h0, sdir_ff, mode_ff};
        ADDR_FIFO_LAT: prdata_ff <= {27'h0, lat_ff};
        ADDR_STATUS:   prdata_ff <= {30'h0, sticky_ff};
        default:       prdata_ff <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_written_ff <= 1'b0;
    end else if (wr_ctrl | wr_lat) begin
      cfg_written_ff <= 1'b1;
    end
  end

  AST_RESET_VAL: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_written_ff |-> (mode_ff == SBC_MODE_RST && lat_ff == LAT_RST && rx_serial_clock_pin_oe))
    else $error("mode or latency left its reset value without a write");
  AST_LAT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_lat |=> (lat_ff == $past(pwdata[LAT_MSB:0])))
    else $error("latency field did not take the written value");
  AST_MODE_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[1:0] == MODE_SLIP) |=> (slip_mode && !rx_serial_clock_pin_oe))
    else $error("writing 01 did not select slip-buffer operation");

  // Write side of the buffer, on pclk.
  logic [1:0]  mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] wr_gray_ff;
  logic [AW:0] rg_s1_ff;
  logic [AW:0] rg_s2_ff;
  logic [AW:0] rd_gray_ff;
  logic        drop_ff;
  logic [AW:0] fill_w;
  logic [AW:0] free_w;
  logic        full;
  logic        start;
  logic        drop_evt;
  logic        drop_now;
  logic        wr_en;
  logic [AW:0] nxt_wr_ptr;

  always_comb begin
    fill_w     = wr_ptr_ff - gray2bin(rg_s2_ff);
    free_w     = DEPTH_W - fill_w;
    full       = (fill_w == DEPTH_W);
    start      = line_bit_valid & line_frame_start;
    drop_evt   = start & slip_mode & (free_w < FRAME_W);
    drop_now   = start ? drop_evt : drop_ff;
    wr_en      = buf_mode & line_bit_valid & ~full & ~drop_now;
    nxt_wr_ptr = wr_ptr_ff + (AW+1)'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rg_s1_ff <= '0;
      rg_s2_ff <= '0;
    end else begin
      rg_s1_ff <= rd_gray_ff;
      rg_s2_ff <= rg_s1_ff;
    end
  end

  // In slip mode, a frame that cannot fit whole is skipped until the next frame start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_ff <= 1'b0;
    end else if (start) begin
      drop_ff <= drop_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff  <= '0;
      wr_gray_ff <= '0;
    end else if (wr_en) begin
      wr_ptr_ff  <= nxt_wr_ptr;
      wr_gray_ff <= nxt_wr_ptr ^ (nxt_wr_ptr >> 1);
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= {line_frame_start, line_bit};
    end
  end

  AST_SLIP_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    (slip_mode && start && free_w < FRAME_W) |-> (!wr_en ##1 (drop_ff && sticky_ff[ST_DROP_BIT])))
    else $error("slip mode wrote into a frame that could not fit");

  // Configuration handshake toward the link domain.
  localparam logic [7:0] CFG_RST = {1'b0, 1'b0, SBC_SDIR_RST, LAT_RST};
  logic [7:0] cfg_hold_ff;
  logic       cfg_tgl_ff;
  logic       ack_s1_ff;
  logic       ack_s2_ff;
  logic [7:0] cfg_now;

  assign cfg_now = {fifo_mode, slip_mode, sdir_ff, lat_ff};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_hold_ff <= CFG_RST;
      cfg_tgl_ff  <= 1'b0;
    end else if ((cfg_tgl_ff == ack_s2_ff) && (cfg_now != cfg_hold_ff)) begin
      cfg_hold_ff <= cfg_now;
      cfg_tgl_ff  <= ~cfg_tgl_ff;
    end
  end

  // Link domain on the backplane serial clock.
  logic          lrst_s1_ff;
  logic          lrst_n_ff;
  logic          tgl_s1_ff;
  logic          tgl_s2_ff;
  logic          lk_seen_ff;
  logic [7:0]    lk_cfg_ff;
  logic [AW:0]   wg_s1_ff;
  logic [AW:0]   wg_s2_ff;
  logic          fs_s1_ff;
  logic          fs_s2_ff;
  logic          fs_s3_ff;
  logic [AW:0]   rd_ptr_ff;
  logic [AW:0]   rep_ptr_ff;
  logic [$clog2(FRAME_BITS)-1:0] fcnt_ff;
  rsb_rd_state_t rd_state_ff;
  rsb_rd_state_t nxt_rd_state;
  logic          rep_tgl_ff;
  logic          lk_data_ff;
  logic          lk_sync_ff;
  logic          lk_fifo;
  logic          lk_slip;
  logic          lk_sdir;
  logic [AW:0]   fill_r;
  logic          frame_end;
  logic          rd_adv;
  logic          rep_adv;
  logic [AW:0]   nxt_rd_ptr;
  logic [AW-1:0] rd_addr;

  always_ff @(posedge rx_serial_clock_pin_i or negedge presetn) begin
    if (!presetn) begin
      lrst_s1_ff <= 1'b0;
      lrst_n_ff  <= 1'b0;
    end else begin
      lrst_s1_ff <= 1'b1;
      lrst_n_ff  <= lrst_s1_ff;
    end
  end

  always_ff @(posedge rx_serial_clock_pin_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      tgl_s1_ff  <= 1'b0;
      tgl_s2_ff  <= 1'b0;
      lk_seen_ff <= 1'b0;
      lk_cfg_ff  <= CFG_RST;
      wg_s1_ff   <= '0;
      wg_s2_ff   <= '0;
      fs_s1_ff   <= 1'b0;
      fs_s2_ff   <= 1'b0;
      fs_s3_ff   <= 1'b0;
    end else begin
      tgl_s1_ff  <= cfg_tgl_ff;
      tgl_s2_ff  <= tgl_s1_ff;
      lk_seen_ff <= tgl_s2_ff;
      if (tgl_s2_ff != lk_seen_ff) begin
        lk_cfg_ff <= cfg_hold_ff;
      end
      wg_s1_ff   <= wr_gray_ff;
      wg_s2_ff   <= wg_s1_ff;
      fs_s1_ff   <= rx_frame_sync_pin_i;
      fs_s2_ff   <= fs_s1_ff;
      fs_s3_ff   <= fs_s2_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= lk_seen_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  always_comb begin
    lk_fifo      = lk_cfg_ff[7];
    lk_slip      = lk_cfg_ff[6];
    lk_sdir      = lk_cfg_ff[5];
    fill_r       = gray2bin(wg_s2_ff) - rd_ptr_ff;
    frame_end    = (fcnt_ff == ($clog2(FRAME_BITS))'(FRAME_BITS - 1));
    nxt_rd_state = rd_state_ff;
    unique case (rd_state_ff)
      RD_IDLE: begin
        if (lk_fifo && fill_r != '0 && fill_r >= (AW+1)'(lk_cfg_ff[4:0])) begin
          nxt_rd_state = RD_RUN;
        end else if (lk_slip && frame_end && fill_r >= FRAME_W) begin
          nxt_rd_state = RD_RUN;
        end
      end
      RD_RUN: begin
        if (lk_fifo && fill_r == '0) begin
          nxt_rd_state = RD_IDLE;
        end else if (lk_slip && frame_end && fill_r < FRAME_W) begin
          nxt_rd_state = RD_REPEAT;
        end else if (!lk_fifo && !lk_slip) begin
          nxt_rd_state = RD_IDLE;
        end
      end
      RD_REPEAT: begin
        if (!lk_slip) begin
          nxt_rd_state = RD_IDLE;
        end else if (frame_end && fill_r >= FRAME_W) begin
          nxt_rd_state = RD_RUN;
        end
      end
    endcase
    rd_adv     = (rd_state_ff == RD_RUN) && fill_r != '0;
    rep_adv    = (rd_state_ff == RD_REPEAT);
    nxt_rd_ptr = rd_ptr_ff + (AW+1)'(1);
    rd_addr    = rep_adv ? rep_ptr_ff[AW-1:0] : rd_ptr_ff[AW-1:0];
  end

  always_ff @(posedge rx_serial_clock_pin_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      rd_state_ff <= RD_IDLE;
    end else begin
      rd_state_ff <= nxt_rd_state;
    end
  end

  // Frame counter follows the backplane sync when that pin is an input.
  always_ff @(posedge rx_serial_clock_pin_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      fcnt_ff <= '0;
    end else if (lk_sdir && fs_s2_ff && !fs_s3_ff) begin
      fcnt_ff <= '0;
    end else begin
      fcnt_ff <= fcnt_ff + 1'b1;
    end
  end

  // On a slip-mode underflow the last frame is replayed from behind the read pointer.
  always_ff @(posedge rx_serial_clock_pin_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      rd_ptr_ff  <= '0;
      rd_gray_ff <= '0;
      rep_ptr_ff <= '0;
      rep_tgl_ff <= 1'b0;
    end else begin
      if (rd_adv) begin
        rd_ptr_ff  <= nxt_rd_ptr;
        rd_gray_ff <= nxt_rd_ptr ^ (nxt_rd_ptr >> 1);
      end
      if (nxt_rd_state == RD_REPEAT && frame_end) begin
        rep_ptr_ff <= rd_ptr_ff - FRAME_W;
        rep_tgl_ff <= ~rep_tgl_ff;
      end else if (rep_adv) begin
        rep_ptr_ff <= rep_ptr_ff + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge rx_serial_clock_pin_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      lk_data_ff <= 1'b0;
      lk_sync_ff <= 1'b0;
    end else if (rd_adv || rep_adv) begin
      lk_data_ff <= mem_ff[rd_addr][0];
      lk_sync_ff <= mem_ff[rd_addr][1];
    end else begin
      lk_data_ff <= 1'b0;
      lk_sync_ff <= 1'b0;
    end
  end

  AST_FIFO_START: assert property (@(posedge rx_serial_clock_pin_i) disable iff (!lrst_n_ff)
    (lk_fifo && rd_state_ff == RD_IDLE && nxt_rd_state == RD_RUN) |-> (fill_r >= (AW+1)'(lk_cfg_ff[4:0])))
    else $error("FIFO read started before the latency was reached");
  AST_LAT_IGNORED: assert property (@(posedge rx_serial_clock_pin_i) disable iff (!lrst_n_ff)
    (lk_slip && rd_state_ff == RD_IDLE && fill_r < FRAME_W) |=> (rd_state_ff != RD_RUN))
    else $error("slip mode started reading by the latency value");
  AST_SLIP_REPEAT: assert property (@(posedge rx_serial_clock_pin_i) disable iff (!lrst_n_ff)
    (rd_state_ff == RD_RUN && lk_slip && frame_end && fill_r < FRAME_W) |=> (rd_state_ff == RD_REPEAT && !rd_adv))
    else $error("slip underflow did not replay a frame");

  // Repeat events cross back to pclk as a toggle.
  logic rep_s1_ff;
  logic rep_s2_ff;
  logic rep_s3_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_s1_ff <= 1'b0;
      rep_s2_ff <= 1'b0;
      rep_s3_ff <= 1'b0;
    end else begin
      rep_s1_ff <= rep_tgl_ff;
      rep_s2_ff <= rep_s1_ff;
      rep_s3_ff <= rep_s2_ff;
    end
  end

  assign sticky_set = {rep_s2_ff ^ rep_s3_ff, drop_evt};

  // Bypass path: clock, data and sync generated on pclk.
  logic [BCW-1:0] byp_cnt_ff;
  logic           byp_clk_ff;
  logic           byp_hold_ff;
  logic           byp_shold_ff;
  logic           byp_data_ff;
  logic           byp_sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_cnt_ff <= '0;
      byp_clk_ff <= 1'b0;
    end else if (byp_cnt_ff == BYP_LAST) begin
      byp_cnt_ff <= '0;
      byp_clk_ff <= ~byp_clk_ff;
    end else begin
      byp_cnt_ff <= byp_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byp_hold_ff  <= 1'b0;
      byp_shold_ff <= 1'b0;
      byp_data_ff  <= 1'b0;
      byp_sync_ff  <= 1'b0;
    end else begin
      if (line_bit_valid) begin
        byp_hold_ff  <= line_bit;
        byp_shold_ff <= line_frame_start;
      end
      if (byp_cnt_ff == BYP_LAST && byp_clk_ff) begin
        byp_data_ff <= byp_hold_ff;
        byp_sync_ff <= byp_shold_ff;
      end
    end
  end

  // Pin directions follow the mode field and sync direction bit.
  always_comb begin
    rx_serial_clock_pin_o  = byp_clk_ff;
    rx_serial_clock_pin_oe = ~buf_mode;
    rx_frame_sync_pin_oe   = ~buf_mode | ~sdir_ff;
    rx_frame_sync_pin_o    = buf_mode ? lk_sync_ff : byp_sync_ff;
    rx_data_o              = buf_mode ? lk_data_ff : byp_data_ff;
  end

  AST_BYPASS_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && (pwdata[1:0] == 2'h0 || pwdata[1:0] == 2'h3)) |=> (rx_serial_clock_pin_oe && rx_frame_sync_pin_oe))
    else $error("bypass mode left a backplane pin undriven");
  AST_BUF_CLK_IN: assert property (@(posedge pclk) disable iff (!presetn)
    (fifo_mode || slip_mode) |-> (!rx_serial_clock_pin_oe && rx_data_o == lk_data_ff))
    else $error("serial clock pin driven in a buffered mode");
  AST_SYNC_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[1:0] == MODE_FIFO) |=> (rx_frame_sync_pin_oe == !$past(pwdata[SBC_SDIR_BIT])))
    else $error("frame sync pin direction does not follow the direction bit");

endmodule

// ### testbench/rsb_backplane_model.sv
// Backplane partner model: supplies the serial clock and frame sync and counts received ones.
`timescale 1ns/100ps
module rsb_backplane_model #(
  parameter int unsigned FRAME_BITS = 32
) (
  // Pin levels as resolved on the wires.
  input  wire logic        clk_w,
  input  wire logic        data_in,
  // Model drivers onto the backplane pins.
  output logic             clk_drv,
  output logic             sync_drv,
  // Count of ones seen on the data pin.
  output int unsigned      n_ones
);
  int unsigned cnt;

  // The backplane clock runs free, out of phase with pclk.
  initial begin
    clk_drv = 1'b0;
    #3.7;
    forever #6 clk_drv = ~clk_drv;
  end

  // One sync pulse per frame; the wire ignores it while the device drives the pin.
  initial cnt = 0;
  initial sync_drv = 1'b0;
  always @(posedge clk_drv) begin
    cnt <= (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    sync_drv <= (cnt == 0);
  end

  initial n_ones = 0;
  always @(posedge clk_w) begin
    if (data_in === 1'b1) n_ones <= n_ones + 1;
  end
endmodule

// ### testbench/tb_rx_slip_buffer_mode_control.sv
// Self-checking bench for the receive slip buffer mode control.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_mismatch++; $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end
module tb_rx_slip_buffer_mode_control;
  import rsb_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000_0015;
  logic        pready, pslverr, line_bit = 1'b0, line_bit_valid = 1'b0, line_frame_start = 1'b0;
  logic        clk_o, clk_oe, sync_o, sync_oe, rx_data, mdl_clk, mdl_sync, sclk_w, sync_w;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  int unsigned n_ones, snap, lat;
  int          n_mismatch = 0, n_tests = 0;

  always #12.5 pclk = ~pclk;
  assign sclk_w = clk_oe ? clk_o : mdl_clk;
  assign sync_w = sync_oe ? sync_o : mdl_sync;

  rsb_top #(.DEPTH(64), .FRAME_BITS(32)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_bit(line_bit),
    .line_bit_valid(line_bit_valid), .line_frame_start(line_frame_start), .rx_serial_clock_pin_i(sclk_w),
    .rx_serial_clock_pin_o(clk_o), .rx_serial_clock_pin_oe(clk_oe), .rx_frame_sync_pin_i(sync_w),
    .rx_frame_sync_pin_o(sync_o), .rx_frame_sync_pin_oe(sync_oe), .rx_data_o(rx_data));

  rsb_backplane_model #(.FRAME_BITS(32)) i_bp (
    .clk_w(sclk_w), .data_in(rx_data), .clk_drv(mdl_clk), .sync_drv(mdl_sync), .n_ones(n_ones));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic er);
    exp_q.push_back({er, ex});
    apb(a, 1'b0, 32'h0);
  endtask

  // Read results are matched against the oldest note when the access completes.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      note = exp_q.pop_front();
      `CHK("apb read", note, {pslverr, prdata})
    end
  end

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic feed(input int unsigned n);
    for (int unsigned i = 0; i < n; i++) begin
      @(posedge pclk);
      line_bit_valid <= 1'b1;
      line_bit <= 1'b1;
      line_frame_start <= (i == 0);
      @(posedge pclk);
      line_bit_valid <= 1'b0;
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    do_reset();
    @(posedge pclk);
    #1;
    `CHK("clock oe", 1'b1, clk_oe)
    `CHK("sync oe", 1'b1, sync_oe)
    rd(ADDR_SB_CTRL, {29'h0, SBC_SDIR_RST, SBC_MODE_RST}, 1'b0);
    rd(ADDR_FIFO_LAT, {27'h0, LAT_RST}, 1'b0);
    seed = xs(seed);
    apb(ADDR_FIFO_LAT, 1'b1, seed);
    rd(ADDR_FIFO_LAT, {27'h0, seed[4:0]}, 1'b0);
    apb(12'h010, 1'b1, seed);
    rd(12'h010, 32'h0, 1'b1);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        apb(ADDR_SB_CTRL, 1'b1, {29'h0, s[0], m[1:0]});
        @(posedge pclk);
        #1;
        `CHK("clock oe", (m == 0 || m == 3), clk_oe)
        `CHK("sync oe", (m == 0 || m == 3 || s == 0), sync_oe)
        rd(ADDR_SB_CTRL, {29'h0, s[0], m[1:0]}, 1'b0);
      end
    end
    // Slip mode with less than a frame stored must not output data.
    do_reset();
    apb(ADDR_FIFO_LAT, 1'b1, 32'h0000_0002);
    apb(ADDR_SB_CTRL, 1'b1, {29'h0, 1'b0, MODE_SLIP});
    repeat (20) @(posedge pclk);
    snap = n_ones;
    feed(8);
    repeat (100) @(posedge pclk);
    `CHK("slip ones", 0, n_ones - snap)
    rd(ADDR_STATUS, 32'h0, 1'b0);
    // FIFO mode holds data until the latency is reached, then releases it all.
    do_reset();
    seed = xs(seed);
    lat = 2 + seed % 16;
    apb(ADDR_FIFO_LAT, 1'b1, lat);
    apb(ADDR_SB_CTRL, 1'b1, {29'h0, 1'b1, MODE_FIFO});
    repeat (20) @(posedge pclk);
    snap = n_ones;
    feed(lat - 1);
    repeat (100) @(posedge pclk);
    `CHK("fifo early", 0, n_ones - snap)
    feed(1);
    repeat (100) @(posedge pclk);
    `CHK("fifo ones", lat, n_ones - snap)
    // Bypass passes line data straight to the backplane pin.
    do_reset();
    snap = n_ones;
    repeat (40) @(posedge pclk);
    `CHK("bypass idle", 0, n_ones - snap)
    feed(1);
    repeat (60) @(posedge pclk);
    `CHK("bypass data", 1'b1, n_ones != snap)
    close_out();
  end
endmodule
